// file: pkg/svspr_pkg.sv
`default_nettype none
package svspr_pkg;
	// Special register numbers.
	localparam logic [9:0] SPR_FAULT_CAUSE = 10'h012;
	localparam logic [9:0] SPR_FAULT_ADDR = 10'h013;
	localparam logic [9:0] SPR_DOWN_COUNTER = 10'h016;
	localparam logic [9:0] SPR_SAVE_RESUME = 10'h01a;
	localparam logic [9:0] SPR_SAVE_STATE = 10'h01b;
	localparam logic [9:0] SPR_IRQ_ON_REC = 10'h050;
	localparam logic [9:0] SPR_IRQ_OFF_REC = 10'h051;
	localparam logic [9:0] SPR_IRQ_OFF_UNREC = 10'h052;
	localparam logic [9:0] SPR_TIME_LOWER_WR = 10'h11c;
	localparam logic [9:0] SPR_TIME_UPPER_WR = 10'h11d;
	localparam logic [9:0] SPR_TIME_LOWER_RD = 10'h10c;
	localparam logic [9:0] SPR_TIME_UPPER_RD = 10'h10d;
	localparam logic [9:0] SPR_CORE_VERSION = 10'h11f;
	localparam logic [9:0] SPR_SCRATCH0 = 10'h110;
	localparam logic [9:0] SPR_ICACHE_CST = 10'h230;
	// State word bit positions, numbered with bit 0 as the most significant.
	localparam int MSW_EXC_LE = 15;
	localparam int MSW_EXT_IRQ_ON = 16;
	localparam int MSW_PRIV = 17;
	localparam int MSW_FP_TRAP_HI = 20;
	localparam int MSW_STEP_TRACE = 21;
	localparam int MSW_BRANCH_TRACE = 22;
	localparam int MSW_FP_TRAP_LO = 23;
	localparam int MSW_VECTOR_HIGH = 25;
	localparam int MSW_RECOVERABLE = 30;
	localparam int MSW_BYTE_ORDER = 31;
	localparam int DOWN_MSB = 0;
	localparam logic [31:0] MSW_WRITABLE_MASK = 32'h0001_ff43;
	localparam logic [31:0] MSW_RESET = 32'h0000_0000;
	localparam logic [31:0] SAVE_LOW_MASK = 32'h0000_ffff;
	localparam logic [31:0] VECTOR_BASE_LOW = 32'h0000_0000;
	localparam logic [31:0] VECTOR_BASE_HIGH = 32'hfff0_0000;
	localparam logic [31:0] CORE_VERSION_VAL = 32'h0001_0001;
	localparam logic [63:0] TIME_ONE = 64'h0000_0000_0000_0001;
	localparam logic [31:0] DOWN_ONE = 32'h0000_0001;
	// Counter clock timing.
	localparam int CORE_CLOCK_HZ = 10000000;
	localparam int TICK_HZ = 1000000;
	localparam int TICK_DIV = CORE_CLOCK_HZ / TICK_HZ;
	localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);
	// Access outcomes reported back to the core.
	typedef enum logic [1:0] {
		SVSPR_OK = 2'b00,
		SVSPR_PRIV_FAULT = 2'b01,
		SVSPR_EMUL_FAULT = 2'b10
	} svspr_result_t;
endpackage : svspr_pkg
`default_nettype wire

// file: verilog/svspr_file.sv
// Function
// - Step trace forces ordered dispatch, traps each instruction
// - Branch trace traps every completed branch
// - State bit 25 selects vector table base
// - State bit 30 marks recoverable machine state
// - State bit 31 selects little-endian byte order
// - Nonzero floating trap mode invokes precise handler
// - Fault cause loaded on data/alignment faults
// - Alignment fault loads fault address register
// - Time count written per half, supervisor only
// - Upper half high order, lower half low
// - Down counter read harmless, write replaces all
// - Sign rise posts request; taking cancels extras
// - Software write sign rise also posts request
// - Down counter ignores reset, keeps counting on internal clock
// - Counters tick from selectable divided clock
// - Resume address saved per exception, syscall next
// - Save state: info high, state word low
// - Four scratch registers unchanged by reset
// - Version register read-only, supervisor only
// - Implementation registers reachable only in supervisor
// - Shortcut writes set or clear enable, recoverable
// - Supervisor reads of shortcut registers raise emulation fault; user reads raise privilege fault
// - Interrupt enable gates external and counter exceptions
`default_nettype none
module svspr_file
	import svspr_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Special register access from the execution stage.
	input wire logic sprWrite,
	input wire logic sprRead,
	input wire logic [9:0] sprNum,
	input wire logic [31:0] sprWrData,
	output logic [31:0] sprRdData,
	output svspr_pkg::svspr_result_t sprResult,
	// State word moves and return from exception.
	input wire logic stateWrite,
	input wire logic [31:0] stateWrData,
	input wire logic returnFromExc,
	output logic [31:0] machineStateWord,
	// Exception entry.
	input wire logic excTake,
	input wire logic excIsCounter,
	input wire logic [31:0] excResumeAddr,
	input wire logic [15:0] excInfo,
	input wire logic excDataFault,
	input wire logic excAlignFault,
	input wire logic [31:0] excFaultCause,
	input wire logic [31:0] excFaultAddr,
	// Instruction completion for trace.
	input wire logic instrDone,
	input wire logic instrIsBranch,
	input wire logic instrOtherExc,
	input wire logic fpEnabledExc,
	// Counter clock control.
	input wire logic counterClockOn,
	input wire logic counterClockSelExt,
	input wire logic extCounterClock,
	// Control outputs to the core.
	input wire logic externalIrq,
	output logic traceExcReq,
	output logic strictOrder,
	output logic fpAssistReq,
	output logic [31:0] vectorBase,
	output logic byteOrderLittle,
	output logic stateRecoverable,
	output logic counterExcPending,
	output logic counterExcTake,
	output logic externalExcTake
);
	import svspr_pkg::*;

	// Bit index with bit 0 as most significant.
	function automatic int bx(input int b);
		bx = 31 - b;
	endfunction : bx

	logic [31:0] msw_q, msw_d;
	logic [31:0] faultCause_q, faultAddr_q, resume_q, saveState_q;
	logic [31:0] down_q, down_d;
	logic [63:0] time_q, time_d;
	logic [31:0] scratch_q [4];
	logic [3:0] div_q;
	logic [2:0] extSync_q;
	logic extLevel_q, extPrev_q;
	logic pending_q;

	// Named state word fields; bit 0 of the word is its most significant bit.
	wire extIrqOn = msw_q[bx(MSW_EXT_IRQ_ON)];
	wire stepTraceOn = msw_q[bx(MSW_STEP_TRACE)];
	wire branchTraceOn = msw_q[bx(MSW_BRANCH_TRACE)];
	wire fpTrapModeHi = msw_q[bx(MSW_FP_TRAP_HI)];
	wire fpTrapModeLo = msw_q[bx(MSW_FP_TRAP_LO)];
	wire vectorHighBase = msw_q[bx(MSW_VECTOR_HIGH)];

	// Privilege and decode.
	wire userMode = msw_q[bx(MSW_PRIV)];
	wire hitFaultCause = (sprNum == SPR_FAULT_CAUSE);
	wire hitFaultAddr = (sprNum == SPR_FAULT_ADDR);
	wire hitDown = (sprNum == SPR_DOWN_COUNTER);
	wire hitResume = (sprNum == SPR_SAVE_RESUME);
	wire hitSaveState = (sprNum == SPR_SAVE_STATE);
	wire hitIrqOnRec = (sprNum == SPR_IRQ_ON_REC);
	wire hitIrqOffRec = (sprNum == SPR_IRQ_OFF_REC);
	wire hitIrqOffUnrec = (sprNum == SPR_IRQ_OFF_UNREC);
	wire hitTimeLoWr = (sprNum == SPR_TIME_LOWER_WR);
	wire hitTimeHiWr = (sprNum == SPR_TIME_UPPER_WR);
	wire hitTimeLoRd = (sprNum == SPR_TIME_LOWER_RD);
	wire hitTimeHiRd = (sprNum == SPR_TIME_UPPER_RD);
	wire hitVersion = (sprNum == SPR_CORE_VERSION);
	wire isShortcut = hitIrqOnRec || hitIrqOffRec || hitIrqOffUnrec;
	wire isScratch = (sprNum[9:2] == SPR_SCRATCH0[9:2]);
	wire isUserReadable = hitTimeLoRd || hitTimeHiRd;
	wire isKnown = isShortcut || isScratch || isUserReadable
		|| hitFaultCause || hitFaultAddr || hitDown || hitResume || hitSaveState
		|| hitTimeLoWr || hitTimeHiWr || hitVersion;
	// Time count reads are the only accesses left open to user mode.
	wire anyAccess = sprRead || sprWrite;
	wire userReadOk = sprRead && isUserReadable;
	wire privFault = userMode && anyAccess && isKnown && !userReadOk;
	wire emulFault = sprRead && isShortcut && !privFault;
	wire readOnlyWr = hitVersion || isUserReadable;
	wire rdOk = sprRead && !privFault && !emulFault;
	wire wrOk = sprWrite && !privFault && !readOnlyWr;
	wire wrDown = wrOk && hitDown;
	wire wrTimeLo = wrOk && hitTimeLoWr;
	wire wrTimeHi = wrOk && hitTimeHiWr;
	wire wrResume = wrOk && hitResume;
	wire wrSaveState = wrOk && hitSaveState;
	wire wrFaultCause = wrOk && hitFaultCause;
	wire wrFaultAddr = wrOk && hitFaultAddr;
	wire wrScratch = wrOk && isScratch;
	wire wrShortcut = wrOk && isShortcut;

	assign sprResult = privFault ? SVSPR_PRIV_FAULT : (emulFault ? SVSPR_EMUL_FAULT : SVSPR_OK);

	// Read data; a read never disturbs a counter.
	// Reads return zero when refused, so a faulted read leaks nothing.
	wire [31:0] scratchRd = scratch_q[sprNum[1:0]];
	always_comb begin
		sprRdData = '0;
		if (rdOk) begin
			case (sprNum)
				SPR_FAULT_CAUSE: sprRdData = faultCause_q;
				SPR_FAULT_ADDR: sprRdData = faultAddr_q;
				SPR_DOWN_COUNTER: sprRdData = down_q;
				SPR_SAVE_RESUME: sprRdData = resume_q;
				SPR_SAVE_STATE: sprRdData = saveState_q;
				SPR_TIME_UPPER_RD: sprRdData = time_q[63:32];
				SPR_TIME_LOWER_RD: sprRdData = time_q[31:0];
				SPR_CORE_VERSION: sprRdData = CORE_VERSION_VAL;
				default: sprRdData = isScratch ? scratchRd : '0;
			endcase
		end
	end

	// Counter clock: internal divider or synchronised external source.
	wire extRise = extLevel_q && !extPrev_q;
	wire intTick = (div_q == TICK_LAST);
	wire tick = counterClockOn && (counterClockSelExt ? extRise : intTick);

	// The divider has no reset, so ticks go on through reset; a down counter write realigns it.
	// Ticks stay unknown in simulation until that first write.
	wire divRestart = intTick || wrDown;
	always_ff @(posedge clock) begin
		div_q <= divRestart ? '0 : div_q + 4'h1;
	end

	// Three flops; a level counts once the last two agree.
	wire extAgree = (extSync_q[2] == extSync_q[1]);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			extSync_q <= '0;
		end else begin
			extSync_q <= {extSync_q[1:0], extCounterClock};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			extLevel_q <= 1'b0;
			extPrev_q <= 1'b0;
		end else begin
			extLevel_q <= extAgree ? extSync_q[2] : extLevel_q;
			extPrev_q <= extLevel_q;
		end
	end

	// Time count: increments per tick; each half written alone.
	// A half write wins over the tick for that half; the other half keeps counting.
	wire [63:0] timeInc = time_q + TIME_ONE;
	always_comb begin
		time_d = tick ? timeInc : time_q;
		if (wrTimeLo) begin
			time_d[31:0] = sprWrData;
		end
		if (wrTimeHi) begin
			time_d[63:32] = sprWrData;
		end
	end

	// Down counter: decrements per tick, write replaces whole value.
	wire [31:0] downDec = down_q - DOWN_ONE;
	assign down_d = wrDown ? sprWrData : (tick ? downDec : down_q);
	wire downSignNow = down_q[bx(DOWN_MSB)];
	wire downSignNext = down_d[bx(DOWN_MSB)];
	wire downRise = !downSignNow && downSignNext;

	// Neither counter has a reset: on the internal divider both keep running through it.
	always_ff @(posedge clock) begin
		time_q <= time_d;
	end

	always_ff @(posedge clock) begin
		down_q <= down_d;
	end

	// Scratch registers keep contents across reset.
	for (genvar i = 0; i < 4; i++) begin : g_scratch
		wire hitThis = wrScratch && (sprNum[1:0] == 2'(i));
		always_ff @(posedge clock) begin
			if (hitThis) begin
				scratch_q[i] <= sprWrData;
			end
		end
	end

	// Pending counter exception: set wins, taking clears extras.
	// A rise in the cycle of a take is a new request, so it must not be lost.
	wire pendingClear = excTake && excIsCounter;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pending_q <= 1'b0;
		end else if (downRise) begin
			pending_q <= 1'b1;
		end else if (pendingClear) begin
			pending_q <= 1'b0;
		end
	end

	assign counterExcPending = pending_q;
	assign counterExcTake = pending_q && extIrqOn;
	assign externalExcTake = externalIrq && extIrqOn;

	// State word next value.
	// Exception entry outranks return, state moves and shortcut writes.
	// Shortcut numbers ignore the written data.
	wire [31:0] mswRestored = (msw_q & ~SAVE_LOW_MASK) | (saveState_q & SAVE_LOW_MASK);
	wire [31:0] mswWritten = stateWrData & MSW_WRITABLE_MASK;
	wire stateWrOk = stateWrite && !userMode;
	always_comb begin
		msw_d = msw_q;
		if (excTake) begin
			msw_d[bx(MSW_EXT_IRQ_ON)] = 1'b0;
			msw_d[bx(MSW_PRIV)] = 1'b0;
			msw_d[bx(MSW_STEP_TRACE)] = 1'b0;
			msw_d[bx(MSW_BRANCH_TRACE)] = 1'b0;
			msw_d[bx(MSW_RECOVERABLE)] = 1'b0;
			msw_d[bx(MSW_BYTE_ORDER)] = msw_q[bx(MSW_EXC_LE)];
		end else if (returnFromExc) begin
			msw_d = mswRestored;
		end else if (stateWrOk) begin
			msw_d = mswWritten;
		end else if (wrShortcut) begin
			msw_d[bx(MSW_EXT_IRQ_ON)] = hitIrqOnRec;
			msw_d[bx(MSW_RECOVERABLE)] = !hitIrqOffUnrec;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			msw_q <= MSW_RESET;
		end else begin
			msw_q <= msw_d;
		end
	end

	// Exception save registers and fault registers.
	// The cause loads on data and alignment faults, the address on alignment only.
	wire loadCause = excTake && (excDataFault || excAlignFault);
	wire loadAddr = excTake && excAlignFault;
	wire [31:0] saveStateEntry = {excInfo, msw_q[15:0]};

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			resume_q <= '0;
		end else if (excTake) begin
			resume_q <= excResumeAddr;
		end else if (wrResume) begin
			resume_q <= sprWrData;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			saveState_q <= '0;
		end else if (excTake) begin
			saveState_q <= saveStateEntry;
		end else if (wrSaveState) begin
			saveState_q <= sprWrData;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			faultCause_q <= '0;
		end else if (loadCause) begin
			faultCause_q <= excFaultCause;
		end else if (wrFaultCause) begin
			faultCause_q <= sprWrData;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			faultAddr_q <= '0;
		end else if (loadAddr) begin
			faultAddr_q <= excFaultAddr;
		end else if (wrFaultAddr) begin
			faultAddr_q <= sprWrData;
		end
	end

	// Control outputs derived from the state word.
	// The trace request drops when the instruction raised anything else.
	wire traceEligible = instrDone && !instrOtherExc;
	wire branchTraced = branchTraceOn && instrIsBranch;
	wire fpTrapOn = fpTrapModeHi || fpTrapModeLo;
	assign machineStateWord = msw_q;
	assign strictOrder = stepTraceOn;
	assign traceExcReq = traceEligible && (stepTraceOn || branchTraced);
	assign fpAssistReq = fpEnabledExc && fpTrapOn;
	assign vectorBase = vectorHighBase ? VECTOR_BASE_HIGH : VECTOR_BASE_LOW;
	assign byteOrderLittle = msw_q[bx(MSW_BYTE_ORDER)];
	assign stateRecoverable = msw_q[bx(MSW_RECOVERABLE)];
endmodule : svspr_file
`default_nettype wire

// file: bench/svspr_file_props.sv
`default_nettype none
module svspr_file_props
	import svspr_pkg::*;
(
	// Watched ports.
	input wire logic clock,
	input wire logic reset_n,
	input wire logic sprWrite,
	input wire logic sprRead,
	input wire logic [9:0] sprNum,
	input wire svspr_pkg::svspr_result_t sprResult,
	input wire logic stateWrite,
	input wire logic excTake,
	input wire logic [31:0] machineStateWord,
	input wire logic fpEnabledExc,
	input wire logic instrDone,
	input wire logic instrIsBranch,
	input wire logic instrOtherExc,
	input wire logic traceExcReq,
	input wire logic strictOrder,
	input wire logic fpAssistReq,
	input wire logic [31:0] vectorBase,
	input wire logic byteOrderLittle,
	input wire logic stateRecoverable,
	input wire logic counterExcTake,
	input wire logic externalExcTake
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [31:0] m = machineStateWord;
	wire logic quiet = !excTake && !stateWrite;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	chk_step_order: assert property (strictOrder == m[10]) else $error("step order");
	chk_vector_base: assert property (
		vectorBase == (m[6] ? VECTOR_BASE_HIGH : VECTOR_BASE_LOW)) else $error("vector base");
	chk_order_recover: assert property (
		byteOrderLittle == m[0] && stateRecoverable == m[1]) else $error("order or recover");
	chk_fp_assist: assert property (
		fpAssistReq == (fpEnabledExc && (m[11] || m[8]))) else $error("fp assist");
	chk_irq_on: assert property (
		sprWrite && sprNum == SPR_IRQ_ON_REC && sprResult == SVSPR_OK && quiet |=> m[15] && m[1])
		else $error("irq on");
	chk_shortcut_read: assert property (
		sprRead && !m[14] && sprNum inside {[SPR_IRQ_ON_REC:SPR_IRQ_OFF_UNREC]}
		|-> sprResult == SVSPR_EMUL_FAULT) else $error("shortcut read");
	chk_user_refused: assert property (
		(sprRead || sprWrite) && m[14] && sprNum == SPR_SCRATCH0 |-> sprResult == SVSPR_PRIV_FAULT)
		else $error("user access");
	chk_irq_gate: assert property (counterExcTake || externalExcTake |-> m[15])
		else $error("irq gate");
	chk_trace_req: assert property (
		traceExcReq == (instrDone && !instrOtherExc && (m[10] || (m[9] && instrIsBranch))))
		else $error("trace request");
	cov_counter_take: cover property (counterExcTake);
	cov_priv_fault: cover property (sprResult == SVSPR_PRIV_FAULT);
	cov_trace: cover property (traceExcReq);
endmodule : svspr_file_props
bind svspr_file svspr_file_props i_props (.clock, .reset_n, .sprWrite, .sprRead, .sprNum,
	.sprResult, .stateWrite, .excTake, .machineStateWord, .fpEnabledExc, .traceExcReq,
	.strictOrder, .fpAssistReq, .vectorBase, .byteOrderLittle, .stateRecoverable,
	.counterExcTake, .externalExcTake, .instrDone, .instrIsBranch, .instrOtherExc);
`default_nettype wire

// file: bench/svspr_core_model.sv
`default_nettype none
module svspr_core_model (
	// Exception entry toward the block.
	input wire logic clock,
	output logic excTake,
	output logic excIsCounter,
	output logic excAlignFault,
	output logic [31:0] excResumeAddr,
	output logic [15:0] excInfo,
	output logic [31:0] excFaultCause,
	output logic [31:0] excFaultAddr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {excTake, excIsCounter, excAlignFault, excResumeAddr, excInfo} = '0;
	initial {excFaultCause, excFaultAddr} = '0;
	task automatic take(input logic [1:0] kind, input logic [31:0] e[4]);
		@(posedge clock);
		excTake <= 1'b1;
		{excIsCounter, excAlignFault} <= kind;
		{excResumeAddr, excInfo, excFaultCause, excFaultAddr} <= {e[0], e[1][15:0], e[2], e[3]};
		@(posedge clock);
		excTake <= 1'b0;
		{excResumeAddr, excInfo, excFaultCause, excFaultAddr} <= ~{e[0], e[1][15:0], e[2], e[3]};
	endtask : take
endmodule : svspr_core_model
`default_nettype wire

// file: bench/svspr_file_tb.sv
`default_nettype none
module svspr_file_tb import svspr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, reset_n, sprWrite, sprRead, stateWrite, counterClockOn, externalIrq, excTake;
	logic instrDone, instrIsBranch, instrOtherExc, fpEnabledExc, excIsCounter, excAlignFault;
	logic counterExcPending, counterExcTake;
	logic [9:0] sprNum;
	logic [31:0] sprWrData, sprRdData, stateWrData, machineStateWord, d, sc[4], e[4];
	logic [31:0] excResumeAddr, excFaultCause, excFaultAddr;
	logic [15:0] excInfo;
	svspr_result_t sprResult;
	logic [33:0] expq[$];
	int n_errors, cmp_count;
	svspr_file i_dut (.clock, .reset_n, .sprWrite, .sprRead, .sprNum, .sprWrData, .sprRdData,
		.sprResult, .stateWrite, .stateWrData, .returnFromExc(1'b0), .machineStateWord, .excTake,
		.excIsCounter, .excResumeAddr, .excInfo, .excDataFault(1'b0), .excAlignFault,
		.excFaultCause, .excFaultAddr, .instrDone, .instrIsBranch, .instrOtherExc, .fpEnabledExc,
		.counterClockOn, .counterClockSelExt(1'b0), .extCounterClock(1'b0), .externalIrq,
		.traceExcReq(), .strictOrder(), .fpAssistReq(), .vectorBase(), .byteOrderLittle(),
		.stateRecoverable(), .counterExcPending, .counterExcTake, .externalExcTake());
	svspr_core_model i_core (.clock, .excTake, .excIsCounter, .excAlignFault, .excResumeAddr,
		.excInfo, .excFaultCause, .excFaultAddr);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Kind 0 reads, 1 writes a register, 2 writes the state word.
	task automatic acc(input int k, input logic [9:0] n, input logic [31:0] v,
		input logic [1:0] r = 2'h0);
		@(posedge clock);
		{sprRead, sprWrite, stateWrite} <= 3'(3'h4 >> k);
		{sprNum, sprWrData, stateWrData} <= {n, v, v};
		if (k == 0) expq.push_back({r, v});
		@(posedge clock);
		{sprRead, sprWrite, stateWrite} <= 3'h0;
	endtask : acc
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	always @(posedge clock) begin
		if (sprRead === 1'b1) chk("read", {sprResult, sprRdData}, expq.pop_front());
	end
	initial begin
		{reset_n, sprWrite, sprRead, stateWrite, counterClockOn, externalIrq} = '0;
		{instrDone, instrIsBranch, instrOtherExc, fpEnabledExc, sprNum, sprWrData} = '0;
		stateWrData = '0;
		void'($urandom(86));
		foreach (sc[i]) sc[i] = $urandom;
		d = sc[0] >> 1;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		acc(1, SPR_DOWN_COUNTER, d);
		acc(1, SPR_TIME_UPPER_WR, d);
		acc(1, SPR_TIME_LOWER_WR, 32'hffff_fff9);
		acc(0, SPR_DOWN_COUNTER, d);
		foreach (sc[i]) acc(1, SPR_SCRATCH0 + 10'(i), sc[i]);
		counterClockOn <= 1'b1;
		repeat (40) @(posedge clock);
		reset_n <= 1'b0;
		repeat (30) @(posedge clock);
		reset_n <= 1'b1;
		repeat (30) @(posedge clock);
		counterClockOn <= 1'b0;
		acc(0, SPR_DOWN_COUNTER, d - 32'h0000_000a);
		acc(0, SPR_TIME_LOWER_RD, 32'h0000_0003);
		acc(0, SPR_TIME_UPPER_RD, d + 32'h0000_0001);
		foreach (sc[i]) acc(0, SPR_SCRATCH0 + 10'(i), sc[i]);
		$display("done: counters");
		acc(1, SPR_CORE_VERSION, ~CORE_VERSION_VAL);
		acc(0, SPR_CORE_VERSION, CORE_VERSION_VAL);
		foreach (sc[i]) acc(0, SPR_IRQ_ON_REC + 10'(i % 3), 32'h0000_0000, SVSPR_EMUL_FAULT);
		foreach (sc[i]) begin
			acc(1, SPR_IRQ_ON_REC + 10'(2 - i % 3), sc[i]);
			#1 chk("enable", {machineStateWord[15], machineStateWord[1]}, {i % 3 == 2, i % 3 != 0});
		end
		$display("done: shortcuts");
		e = sc;
		acc(1, SPR_DOWN_COUNTER, 32'h0000_0000);
		i_core.take(2'b10, e);
		#1 chk("pending", counterExcPending, 1'b0);
		acc(1, SPR_DOWN_COUNTER, 32'h8000_0000);
		acc(1, SPR_DOWN_COUNTER, 32'h0000_0000);
		acc(1, SPR_DOWN_COUNTER, 32'h8000_0000);
		#1 chk("masked", {counterExcPending, counterExcTake}, 2'b10);
		acc(1, SPR_IRQ_ON_REC, 32'h0000_0000);
		#1 chk("take", counterExcTake, 1'b1);
		i_core.take(2'b10, e);
		#1 chk("cancel", {counterExcPending, counterExcTake, machineStateWord}, 34'h0);
		acc(0, SPR_SAVE_RESUME, e[0]);
		acc(0, SPR_SAVE_STATE, {e[1][15:0], 16'h8002});
		foreach (e[i]) e[i] = $urandom;
		i_core.take(2'b01, e);
		acc(0, SPR_FAULT_CAUSE, e[2]);
		acc(0, SPR_FAULT_ADDR, e[3]);
		$display("done: exceptions");
		repeat (8) begin
			{instrDone, instrIsBranch, instrOtherExc, fpEnabledExc, externalIrq} <= 5'($urandom);
			acc(2, SPR_SCRATCH0, $urandom & 32'hffff_bfff);
		end
		acc(2, SPR_SCRATCH0, 32'h0000_4000);
		acc(1, SPR_SCRATCH0, ~sc[0]);
		acc(0, SPR_SCRATCH0, 32'h0000_0000, SVSPR_PRIV_FAULT);
		acc(0, SPR_CORE_VERSION, 32'h0000_0000, SVSPR_PRIV_FAULT);
		acc(0, SPR_TIME_UPPER_RD, d + 32'h0000_0001);
		i_core.take(2'b00, e);
		acc(0, SPR_SCRATCH0, sc[0]);
		$display("done: privilege");
		finish_test();
	end
endmodule : svspr_file_tb
`default_nettype wire
